// ==== logic/dbx_pkg.sv ====
package dbx_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // data overlap around a strobe edge, in ns
  localparam int DATA_GUARD_NS = 100;
  localparam int DATA_GUARD_CYC = (DATA_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe width chosen to exceed both guards
  localparam int STROBE_NS = 500;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // capture deadline after strobe and wait both low, in ns
  localparam int CAPTURE_NS = 100;
  localparam int CAPTURE_CYC = (CAPTURE_NS / CLK_PERIOD_NS) < 1 ? 1 : CAPTURE_NS / CLK_PERIOD_NS;
  localparam int SYNC_DEPTH = 2;
  localparam int CNT_W = 8;
  localparam int EVT_LO = 2;
  localparam int EVT_HI = 7;
  localparam int EVT_N = EVT_HI - EVT_LO + 1;
  localparam logic [7:0] OLD_STATE_ADDR = 8'h18;
  localparam logic [7:0] NEW_STATE_ADDR = 8'h58;
  localparam int SYS_MASK_EXT_BIT = 7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  typedef enum logic [2:0] {
    DBX_IDLE = 3'b000,
    DBX_ST_PULSE = 3'b001,
    DBX_LD_PULSE = 3'b010,
    DBX_LD_WAIT = 3'b011,
    DBX_LD_DONE = 3'b100
  } dbx_state_t;
endpackage : dbx_pkg

// ==== logic/dbx_sync.sv ====
`timescale 1ns/1ps
module dbx_sync
#(
  parameter int DEPTH = 2
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic [DEPTH-1:0] chain_r;
  // first stage feeds only the next stage
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      chain_r <= '0;
    end
    else
    begin
      chain_r <= {chain_r[DEPTH-2:0], d};
    end
  end
  assign q = chain_r[DEPTH-1];
endmodule : dbx_sync

// ==== logic/dbx_evt_latch.sv ====
`timescale 1ns/1ps
module dbx_evt_latch
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic evt_sync,
  input wire logic take,
  output logic pend
);
  logic evt_d_r;
  logic pend_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      evt_d_r <= 1'b0;
    end
    else
    begin
      evt_d_r <= evt_sync;
    end
  end
  // repeats merge; set wins over take
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
    end
    else if (evt_sync && !evt_d_r)
    begin
      pend_r <= 1'b1;
    end
    else if (take)
    begin
      pend_r <= 1'b0;
    end
  end
  assign pend = pend_r;
endmodule : dbx_evt_latch

// ==== logic/dbx_port.sv ====
`timescale 1ns/1ps
// Overview of operation
// - store drives operand byte, held static
// - no parity driven with output lines
// - instruction bits 8-15 pulse the lines
// - sender strobe pulses with timing pulses
// - strobe brackets output byte change 100ns
// - load captures input byte when unblocked
// - generate parity for captured byte
// - load emits timing pulses and fetch strobe
// - fetch strobe raises the far end wait line
// - latch event lines 2-7 until taken
// - report event lines in state bits 26-31
// - high level means asserted
// - interrupt only between instructions, mask set
// - save state at 24, fetch from 88
// - pending requests merged, presented once
// - sample wait after strobe, capture in 100ns
module dbx_port
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic st_req,
  input wire logic ld_req,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] instr_sig,
  output logic busy,
  output logic ld_done,
  output logic [7:0] ld_byte,
  output logic ld_parity,
  input wire logic [7:0] bus_in,
  input wire logic wait_in,
  input wire logic [7:0] evt_in,
  output logic [7:0] bus_out,
  output logic [7:0] sig_out,
  output logic send_strobe,
  output logic fetch_strobe,
  input wire logic instr_end,
  input wire logic sys_mask_ext,
  output logic ext_irq,
  output logic [5:0] ext_code,
  output logic [7:0] old_state_addr,
  output logic [7:0] new_state_addr
);
  import dbx_pkg::*;
  dbx_state_t state_r;
  dbx_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] bus_out_r;
  logic [7:0] sig_out_r;
  logic [7:0] sig_hold_r;
  logic [7:0] byte_hold_r;
  logic send_strobe_r;
  logic fetch_strobe_r;
  logic busy_r;
  logic ld_done_r;
  logic [7:0] ld_byte_r;
  logic ld_parity_r;
  logic ext_irq_r;
  logic [5:0] ext_code_r;
  logic [7:0] old_state_addr_r;
  logic [7:0] new_state_addr_r;
  logic wait_s;
  logic [7:0] bus_in_s;
  logic [7:0] evt_s;
  logic [EVT_N-1:0] pend;
  logic take;
  logic [CNT_W-1:0] guard_c;
  logic [CNT_W-1:0] strobe_c;
  logic [CNT_W-1:0] cap_c;

  assign guard_c = CNT_W'(DATA_GUARD_CYC);
  assign strobe_c = CNT_W'(STROBE_CYC);
  assign cap_c = CNT_W'(CAPTURE_CYC);

  dbx_sync #(.DEPTH(SYNC_DEPTH)) u_wait_sync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(wait_in),
    .q(wait_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_in
      dbx_sync #(.DEPTH(SYNC_DEPTH)) u_bus_sync
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(bus_in[gi]),
        .q(bus_in_s[gi])
      );
      dbx_sync #(.DEPTH(SYNC_DEPTH)) u_evt_sync
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(evt_in[gi]),
        .q(evt_s[gi])
      );
    end
    // peer pulses arrive as event requests
    // lines 0 and 1 are terminated only
    for (gi = EVT_LO; gi <= EVT_HI; gi++)
    begin : g_evt
      dbx_evt_latch u_latch
      (
        .clk_sys(clk_sys),
        .rst(rst),
        .evt_sync(evt_s[gi]),
        .take(take),
        .pend(pend[gi-EVT_LO])
      );
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DBX_IDLE:
      begin
        if (st_req)
        begin
          state_nxt = DBX_ST_PULSE;
        end
        else if (ld_req)
        begin
          state_nxt = DBX_LD_PULSE;
        end
      end
      DBX_ST_PULSE:
      begin
        if (cnt_r == strobe_c - 1'b1)
        begin
          state_nxt = DBX_IDLE;
        end
      end
      DBX_LD_PULSE:
      begin
        if (cnt_r == strobe_c - 1'b1)
        begin
          state_nxt = DBX_LD_WAIT;
        end
      end
      DBX_LD_WAIT:
      begin
        // wait sampled only after strobe ends
        if (!wait_s)
        begin
          state_nxt = DBX_LD_DONE;
        end
      end
      DBX_LD_DONE:
      begin
        state_nxt = DBX_IDLE;
      end
      default:
      begin
        state_nxt = DBX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= DBX_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else if (state_r != state_nxt)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r != {CNT_W{1'b1}})
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sig_hold_r <= 8'h00;
      byte_hold_r <= BYTE_RST;
    end
    else if (state_r == DBX_IDLE && (st_req || ld_req))
    begin
      sig_hold_r <= instr_sig;
      byte_hold_r <= op_byte;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sig_out_r <= 8'h00;
    end
    else if (state_nxt == DBX_ST_PULSE || state_nxt == DBX_LD_PULSE)
    begin
      sig_out_r <= (state_r == DBX_IDLE) ? instr_sig : sig_hold_r;
    end
    else
    begin
      sig_out_r <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      send_strobe_r <= 1'b0;
      fetch_strobe_r <= 1'b0;
    end
    else
    begin
      send_strobe_r <= (state_nxt == DBX_ST_PULSE);
      fetch_strobe_r <= (state_nxt == DBX_LD_PULSE);
    end
  end

  // static byte, changes only on store
  // change after guard, settled guard before strobe end
  // no parity line exists on the output side
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_out_r <= BYTE_RST;
    end
    else if (state_r == DBX_ST_PULSE && cnt_r == guard_c)
    begin
      bus_out_r <= byte_hold_r;
    end
  end

  // capture within deadline of wait drop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ld_byte_r <= 8'h00;
      ld_parity_r <= 1'b0;
      ld_done_r <= 1'b0;
    end
    else
    begin
      ld_done_r <= 1'b0;
      if (state_r == DBX_LD_WAIT && !wait_s && cap_c != '0)
      begin
        ld_byte_r <= bus_in_s;
        ld_parity_r <= ~(^bus_in_s);
        ld_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= (state_nxt != DBX_IDLE);
    end
  end

  // only at instruction end with mask set
  assign take = instr_end && sys_mask_ext && (pend != '0) && !ext_irq_r;

  // old at 24, new from 88
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_irq_r <= 1'b0;
      ext_code_r <= 6'h00;
      old_state_addr_r <= 8'h00;
      new_state_addr_r <= 8'h00;
    end
    else
    begin
      ext_irq_r <= take;
      if (take)
      begin
        // code bit 26 is line 2 ... bit 31 is line 7
        ext_code_r <= {pend[0], pend[1], pend[2], pend[3], pend[4], pend[5]};
        old_state_addr_r <= OLD_STATE_ADDR;
        new_state_addr_r <= NEW_STATE_ADDR;
      end
    end
  end

  assign bus_out = bus_out_r;
  assign sig_out = sig_out_r;
  assign send_strobe = send_strobe_r;
  assign fetch_strobe = fetch_strobe_r;
  assign busy = busy_r;
  assign ld_done = ld_done_r;
  assign ld_byte = ld_byte_r;
  assign ld_parity = ld_parity_r;
  assign ext_irq = ext_irq_r;
  assign ext_code = ext_code_r;
  assign old_state_addr = old_state_addr_r;
  assign new_state_addr = new_state_addr_r;
endmodule : dbx_port

// ==== testbench/dbx_port_assertions.sv ====
`timescale 1ns/1ps
module dbx_port_chk
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic st_req,
  input wire logic ld_req,
  input wire logic [7:0] instr_sig,
  input wire logic busy,
  input wire logic ld_done,
  input wire logic [7:0] ld_byte,
  input wire logic ld_parity,
  input wire logic wait_in,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] sig_out,
  input wire logic send_strobe,
  input wire logic fetch_strobe,
  input wire logic instr_end,
  input wire logic sys_mask_ext,
  input wire logic ext_irq,
  input wire logic [7:0] old_state_addr,
  input wire logic [7:0] new_state_addr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_store_start: assert property (st_req && !busy |=> send_strobe && sig_out == $past(instr_sig))
    else $error("store pulses missing");
  a_load_start: assert property (ld_req && !st_req && !busy |=> fetch_strobe && !send_strobe)
    else $error("load strobe missing");
  a_strobe_width: assert property ($rose(send_strobe) |-> ##99 send_strobe ##1 !send_strobe)
    else $error("strobe width wrong");
  a_data_guard: assert property (!$stable(bus_out) |-> send_strobe && $past(send_strobe, 20) ##20 send_strobe)
    else $error("byte change not bracketed");
  a_parity_odd: assert property (ld_done |-> ld_parity == ~^ld_byte)
    else $error("parity wrong");
  a_capture_gate: assert property (ld_done |-> !$past(wait_in, 2) && !$past(fetch_strobe, 2))
    else $error("capture while blocked");
  a_capture_due: assert property (busy && !send_strobe && !fetch_strobe && $fell(wait_in) |-> ##[1:20] ld_done)
    else $error("capture late");
  a_irq_mask: assert property (ext_irq |-> $past(instr_end) && $past(sys_mask_ext))
    else $error("interrupt while masked");
  a_irq_addr: assert property (ext_irq |=> old_state_addr == 8'h18 && new_state_addr == 8'h58)
    else $error("state addresses wrong");
  c_store: cover property ($fell(send_strobe));
  c_load: cover property (ld_done);
  c_irq: cover property (ext_irq);
endmodule : dbx_port_chk
bind dbx_port dbx_port_chk u_chk
(
  .clk_sys(clk_sys),
  .rst(rst),
  .st_req(st_req),
  .ld_req(ld_req),
  .instr_sig(instr_sig),
  .busy(busy),
  .ld_done(ld_done),
  .ld_byte(ld_byte),
  .ld_parity(ld_parity),
  .wait_in(wait_in),
  .bus_out(bus_out),
  .sig_out(sig_out),
  .send_strobe(send_strobe),
  .fetch_strobe(fetch_strobe),
  .instr_end(instr_end),
  .sys_mask_ext(sys_mask_ext),
  .ext_irq(ext_irq),
  .old_state_addr(old_state_addr),
  .new_state_addr(new_state_addr)
);

// ==== testbench/dbx_far_model.sv ====
`timescale 1ns/1ps
module dbx_far_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fetch_strobe,
  input wire logic [7:0] sig_out,
  input wire logic [7:0] reply,
  output logic [7:0] bus_in,
  output logic wait_in,
  output logic [7:0] evt_in
);
  logic [5:0] cnt_r;
  assign evt_in = sig_out;
  // wait raised long before the byte changes
  // wait dropped 20 cycles after the byte settles
  // wait dropped a fixed time after fetch strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 6'h00;
      bus_in <= 8'h00;
      wait_in <= 1'b1;
    end
    else if (fetch_strobe)
    begin
      cnt_r <= 6'h01;
      wait_in <= 1'b1;
    end
    else if (cnt_r != 6'h00)
    begin
      cnt_r <= (cnt_r == 6'h30) ? 6'h00 : cnt_r + 6'h01;
      if (cnt_r == 6'h08)
      begin
        bus_in <= ~reply;
      end
      if (cnt_r == 6'h1C)
      begin
        bus_in <= reply;
      end
      if (cnt_r == 6'h30)
      begin
        wait_in <= 1'b0;
      end
    end
  end
endmodule : dbx_far_model

// ==== testbench/dbx_port_tb.sv ====
`timescale 1ns/1ps
module dbx_port_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic st_req = 1'b0;
  logic ld_req = 1'b0;
  logic [7:0] op_byte = 8'h00;
  logic [7:0] instr_sig = 8'h00;
  logic instr_end = 1'b0;
  logic sys_mask_ext = 1'b0;
  logic [7:0] reply = 8'h00;
  logic busy, ld_done, ld_parity, wait_in, send_strobe, fetch_strobe, ext_irq;
  logic [7:0] ld_byte, bus_in, evt_in, bus_out, sig_out, old_state_addr, new_state_addr;
  logic [5:0] ext_code;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  dbx_port dut
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .st_req(st_req),
    .ld_req(ld_req),
    .op_byte(op_byte),
    .instr_sig(instr_sig),
    .busy(busy),
    .ld_done(ld_done),
    .ld_byte(ld_byte),
    .ld_parity(ld_parity),
    .bus_in(bus_in),
    .wait_in(wait_in),
    .evt_in(evt_in),
    .bus_out(bus_out),
    .sig_out(sig_out),
    .send_strobe(send_strobe),
    .fetch_strobe(fetch_strobe),
    .instr_end(instr_end),
    .sys_mask_ext(sys_mask_ext),
    .ext_irq(ext_irq),
    .ext_code(ext_code),
    .old_state_addr(old_state_addr),
    .new_state_addr(new_state_addr)
  );
  dbx_far_model far
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .fetch_strobe(fetch_strobe),
    .sig_out(sig_out),
    .reply(reply),
    .bus_in(bus_in),
    .wait_in(wait_in),
    .evt_in(evt_in)
  );
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic fail_wait();
    num_errors++;
    wrap_up();
  endtask : fail_wait
  task automatic do_store(input logic [7:0] b, input logic [7:0] s);
    int n;
    logic [7:0] old;
    old = bus_out;
    op_byte = b;
    instr_sig = s;
    st_req = 1'b1;
    tick();
    st_req = 1'b0;
    check(send_strobe, 1'b1);
    check(sig_out, s);
    repeat (4) tick();
    // request while busy must be ignored
    op_byte = ~b;
    st_req = 1'b1;
    tick();
    st_req = 1'b0;
    repeat (14) tick();
    check(bus_out, old);
    repeat (3) tick();
    check(bus_out, b);
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      tick();
      n++;
    end
    if (n == 200)
      fail_wait();
    check(bus_out, b);
    check(sig_out, 8'h00);
    $display("store %h done", b);
  endtask : do_store
  task automatic do_load(input logic [7:0] r, input logic [7:0] s);
    int n;
    reply = r;
    instr_sig = s;
    ld_req = 1'b1;
    tick();
    ld_req = 1'b0;
    check(fetch_strobe, 1'b1);
    check(send_strobe, 1'b0);
    check(sig_out, s);
    n = 0;
    while (ld_done !== 1'b1 && n < 300)
    begin
      tick();
      n++;
    end
    if (n == 300)
      fail_wait();
    check(fetch_strobe, 1'b0);
    check(ld_byte, r);
    check(ld_parity, ~^r);
    // busy drops in the cycle after the capture pulse
    tick();
    check(busy, 1'b0);
    $display("load %h done", r);
  endtask : do_load
  task automatic count_irq(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      tick();
      if (ext_irq === 1'b1)
        c++;
    end
  endtask : count_irq
  task automatic do_events();
    int c;
    do_store(8'h11, 8'h35);
    do_store(8'h22, 8'h04);
    instr_end = 1'b1;
    count_irq(10, c);
    check(8'(c), 8'h00);
    sys_mask_ext = 1'b1;
    count_irq(1, c);
    check(8'(c), 8'h01);
    check(ext_code, 6'h2C);
    tick();
    check(old_state_addr, 8'h18);
    check(new_state_addr, 8'h58);
    count_irq(20, c);
    check(8'(c), 8'h00);
    sys_mask_ext = 1'b0;
    instr_end = 1'b0;
    $display("events done");
  endtask : do_events
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tick();
    check(bus_out, 8'h00);
    do_events();
    do_store(8'hA5, 8'hFF);
    do_store(8'h5A, 8'h00);
    do_load(8'hA5, 8'h81);
    do_load(8'h00, 8'h7E);
    wrap_up();
  end
endmodule : dbx_port_tb
